/* pkg/gated_timer_defs.svh */
`ifndef GATED_TIMER_DEFS_SVH
`define GATED_TIMER_DEFS_SVH

// ***************************************************************
// register offsets
// ***************************************************************
`define OFS_TIMER_ONE_CONTROL 4'h0
`define OFS_COUNT_LOW_BYTE    4'h1
`define OFS_COUNT_HIGH_BYTE   4'h2
`define OFS_FLAG_REG          4'h3
`define OFS_ENABLE_REG        4'h4
`define OFS_CORE_IRQ_CONTROL  4'h5
`define OFS_COMPARATOR_AUX    4'h6
`define OFS_COMPARE_LOW       4'h7
`define OFS_COMPARE_HIGH      4'h8
`define OFS_CAPTURE_LOW       4'h9
`define OFS_CAPTURE_HIGH      4'ha
`define OFS_CCU_CONTROL       4'hb

// ***************************************************************
// field positions
// ***************************************************************
`define BIT_COUNTER_ON        0
`define BIT_CLOCK_SOURCE      1
`define BIT_SYNC_DISABLE      2
`define BIT_LP_OSC_ENABLE     3
`define BIT_PRESCALE_LO       4
`define BIT_PRESCALE_HI       5
`define BIT_GATE_ENABLE       6
`define BIT_GATE_INVERT       7
`define BIT_ROLLOVER          0
`define BIT_PERIPHERAL_EN     6
`define BIT_GLOBAL_EN         7
`define BIT_COMP_SYNC         0
`define BIT_GATE_SOURCE       1
`define BIT_CCU_CAPTURE       0
`define BIT_CCU_COMPARE       1
`define BIT_CCU_SPECIAL       2
`define BIT_CCU_FLAG          3

// ***************************************************************
// reset values and timing
// ***************************************************************
`define RST_CONTROL           8'h00
`define RST_AUX               8'h02
`define INSTR_DIVIDE          2'h3

`endif

/* pkg/gated_timer_pkg.sv */
package gated_timer_pkg;

    typedef logic [15:0] count_t;
    typedef logic [7:0]  byte_t;

endpackage : gated_timer_pkg

/* hw/gated_sixteen_bit_timer.sv */
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "gated_timer_defs.svh"

module gated_sixteen_bit_timer
    import gated_timer_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       external_clock_pin,
    input  wire logic       gate_pin,
    input  wire logic       second_comparator_output,
    input  wire logic       capture_event,
    input  wire logic       sleep_mode,
    output logic            low_power_osc_on,
    output logic            core_irq,
    output logic            wake_request,
    output logic            compare_match
);

    // ***************************************************************
    // registers
    // ***************************************************************
    byte_t  timer_one_control_r;
    byte_t  aux_r;
    byte_t  ccu_r;
    logic   rollover_flag_r;
    logic   rollover_enable_r;
    logic   peripheral_irq_enable_r;
    logic   global_irq_enable_r;
    count_t count_r;
    count_t compare_pair_r;
    count_t capture_pair_r;
    logic   ccu_flag_r;

    logic   counter_on;
    logic   clock_source_select;
    logic   external_sync_disable;
    logic   gate_enable;
    logic   gate_invert;
    logic   gate_source_select;
    logic   comparator_sync_enable;
    logic [1:0] prescale_select;

    assign counter_on            = timer_one_control_r[`BIT_COUNTER_ON];
    assign clock_source_select   = timer_one_control_r[`BIT_CLOCK_SOURCE];
    assign external_sync_disable = timer_one_control_r[`BIT_SYNC_DISABLE];
    assign gate_enable           = timer_one_control_r[`BIT_GATE_ENABLE];
    assign gate_invert           = timer_one_control_r[`BIT_GATE_INVERT];
    assign prescale_select       =
        timer_one_control_r[`BIT_PRESCALE_HI:`BIT_PRESCALE_LO];
    assign gate_source_select    = aux_r[`BIT_GATE_SOURCE];
    assign comparator_sync_enable = aux_r[`BIT_COMP_SYNC];

    // the oscillator itself is analog; only its enable leaves the block
    assign low_power_osc_on =
        timer_one_control_r[`BIT_LP_OSC_ENABLE];
    logic wr_low;
    logic wr_high;
    logic count_write;
    assign wr_low      = reg_wr && (reg_addr == `OFS_COUNT_LOW_BYTE);
    assign wr_high     = reg_wr && (reg_addr == `OFS_COUNT_HIGH_BYTE);
    assign count_write = wr_low || wr_high;

    // ***************************************************************
    // pin synchronisers
    // ***************************************************************
    logic [2:0] ext_s1_r;
    logic [2:0] ext_s2_r;
    logic       comp_held_r;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ext_s1_r <= 3'h0;
            ext_s2_r <= 3'h0;
        end
        else
        begin
            ext_s1_r <= {second_comparator_output, gate_pin,
                         external_clock_pin};
            ext_s2_r <= ext_s1_r;
        end
    end

    logic ext_clk_s;
    logic gate_pin_s;
    logic comp_s;
    assign ext_clk_s  = ext_s2_r[0];
    assign gate_pin_s = ext_s2_r[1];
    assign comp_s     = ext_s2_r[2];

    // ***************************************************************
    // clock source and edge qualification
    // ***************************************************************
    // one clock domain only: the unsynchronised path still samples the
    // pins, so it differs only in not waiting on the instruction phase and in running in sleep
    logic [1:0] instr_div_r;
    logic       instr_tick;
    logic       ext_prev_r;
    logic       fall_seen_r;
    logic       ext_rise;
    logic       ext_tick;
    logic       src_tick;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            instr_div_r <= 2'h0;
        else
            instr_div_r <= instr_div_r + 2'h1;
    end

    assign instr_tick = (instr_div_r == `INSTR_DIVIDE);
    assign ext_rise   = ext_clk_s && !ext_prev_r;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            ext_prev_r <= 1'b0;
        else
            ext_prev_r <= ext_clk_s;
    end

    // a write or stop re-arms, so a pin held high cannot count at once
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            fall_seen_r <= 1'b0;
        else if (count_write || !counter_on)
            fall_seen_r <= 1'b0;
        else if (!ext_clk_s && ext_prev_r)
            fall_seen_r <= 1'b1;
        else if (ext_rise)
            fall_seen_r <= 1'b1;
    end

    // synchronised counting waits for the next instruction phase
    logic ext_pend_r;
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            ext_pend_r <= 1'b0;
        else if (count_write || !counter_on)
            ext_pend_r <= 1'b0;
        else if (ext_rise && fall_seen_r && !instr_tick)
            ext_pend_r <= 1'b1;
        else if (instr_tick)
            ext_pend_r <= 1'b0;
    end

    always_comb
    begin
        if (external_sync_disable)
            ext_tick = ext_rise && fall_seen_r;
        else
            ext_tick = instr_tick && (ext_pend_r ||
                       (ext_rise && fall_seen_r));
    end

    // internal clock cannot run in sleep; sync path stalls too
    always_comb
    begin
        if (clock_source_select)
            src_tick = ext_tick &&
                       !(sleep_mode && !external_sync_disable);
        else
            src_tick = instr_tick && !sleep_mode;
    end

    // ***************************************************************
    // gate
    // ***************************************************************
    logic gate_raw;
    logic gate_open;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            comp_held_r <= 1'b0;
        else if (!comparator_sync_enable || src_tick)
            comp_held_r <= comp_s;
    end

    assign gate_raw = gate_source_select ? comp_held_r : gate_pin_s;
    assign gate_open = !gate_enable ||
                       (gate_invert ? gate_raw : !gate_raw);

    // ***************************************************************
    // prescaler
    // ***************************************************************
    logic [2:0] pre_cnt_r;
    logic [2:0] pre_mask;
    logic       count_tick;
    logic       run;

    assign run = counter_on && gate_open;

    always_comb
    begin
        unique case (prescale_select)
            2'h0: pre_mask = 3'h0;
            2'h1: pre_mask = 3'h1;
            2'h2: pre_mask = 3'h3;
            2'h3: pre_mask = 3'h7;
        endcase
    end

    assign count_tick = run && src_tick &&
                        ((pre_cnt_r & pre_mask) == pre_mask);

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            pre_cnt_r <= 3'h0;
        else if (count_write)
            pre_cnt_r <= 3'h0;
        else if (run && src_tick)
            pre_cnt_r <= pre_cnt_r + 3'h1;
    end

    // ***************************************************************
    // counter
    // ***************************************************************
    logic special_clear;
    logic rollover;

    // compare against the registered count; single-clock count keeps
    // each byte read clean; with no holding latch a carry can fall between the two reads
    assign compare_match = ccu_r[`BIT_CCU_COMPARE] &&
                           (count_r == compare_pair_r);
    assign special_clear = compare_match && ccu_r[`BIT_CCU_SPECIAL];
    assign rollover      = count_tick && (count_r == 16'hffff) &&
                           !special_clear && !count_write;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            count_r <= 16'h0000;
        else if (wr_low)
            count_r[7:0] <= reg_wdata;
        else if (wr_high)
            count_r[15:8] <= reg_wdata;
        else if (special_clear)
            count_r <= 16'h0000;
        else if (count_tick)
            count_r <= count_r + 16'h0001;
    end

    // ***************************************************************
    // capture/compare time base
    // ***************************************************************
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            capture_pair_r <= 16'h0000;
        else if (ccu_r[`BIT_CCU_CAPTURE] && capture_event)
            capture_pair_r <= count_r;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            ccu_flag_r <= 1'b0;
        else if (compare_match ||
                 (ccu_r[`BIT_CCU_CAPTURE] && capture_event))
            ccu_flag_r <= 1'b1;
        else if (reg_wr && reg_addr == `OFS_CCU_CONTROL &&
                 !reg_wdata[`BIT_CCU_FLAG])
            ccu_flag_r <= 1'b0;
    end

    // ***************************************************************
    // rollover flag and interrupt
    // ***************************************************************
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            rollover_flag_r <= 1'b0;
        else if (rollover)
            rollover_flag_r <= 1'b1;
        else if (reg_wr && reg_addr == `OFS_FLAG_REG &&
                 !reg_wdata[`BIT_ROLLOVER])
            rollover_flag_r <= 1'b0;
    end

    assign core_irq = rollover_flag_r && rollover_enable_r &&
                      peripheral_irq_enable_r &&
                      global_irq_enable_r;
    // wake does not need the global enable
    assign wake_request = sleep_mode && counter_on && rollover_flag_r &&
                          rollover_enable_r &&
                          peripheral_irq_enable_r;

    // ***************************************************************
    // register writes
    // ***************************************************************
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            timer_one_control_r     <= `RST_CONTROL;
            aux_r                   <= `RST_AUX;
            ccu_r                   <= 8'h00;
            rollover_enable_r       <= 1'b0;
            peripheral_irq_enable_r <= 1'b0;
            global_irq_enable_r     <= 1'b0;
            compare_pair_r          <= 16'h0000;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                `OFS_TIMER_ONE_CONTROL: timer_one_control_r <= reg_wdata;
                `OFS_ENABLE_REG:
                    rollover_enable_r <= reg_wdata[`BIT_ROLLOVER];
                `OFS_CORE_IRQ_CONTROL:
                begin
                    peripheral_irq_enable_r <= reg_wdata[`BIT_PERIPHERAL_EN];
                    global_irq_enable_r     <= reg_wdata[`BIT_GLOBAL_EN];
                end
                `OFS_COMPARATOR_AUX: aux_r <= {6'h00, reg_wdata[1:0]};
                `OFS_COMPARE_LOW:    compare_pair_r[7:0]  <= reg_wdata;
                `OFS_COMPARE_HIGH:   compare_pair_r[15:8] <= reg_wdata;
                `OFS_CCU_CONTROL:    ccu_r <= {5'h00, reg_wdata[2:0]};
                default: ;
            endcase
        end
    end

    // ***************************************************************
    // register reads
    // ***************************************************************
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                `OFS_TIMER_ONE_CONTROL: reg_rdata <= timer_one_control_r;
                `OFS_COUNT_LOW_BYTE:    reg_rdata <= count_r[7:0];
                `OFS_COUNT_HIGH_BYTE:   reg_rdata <= count_r[15:8];
                `OFS_FLAG_REG:      reg_rdata <= {7'h00, rollover_flag_r};
                `OFS_ENABLE_REG:    reg_rdata <= {7'h00, rollover_enable_r};
                `OFS_CORE_IRQ_CONTROL:
                    reg_rdata <= {global_irq_enable_r,
                                  peripheral_irq_enable_r, 6'h00};
                `OFS_COMPARATOR_AUX: reg_rdata <= aux_r;
                `OFS_COMPARE_LOW:    reg_rdata <= compare_pair_r[7:0];
                `OFS_COMPARE_HIGH:   reg_rdata <= compare_pair_r[15:8];
                `OFS_CAPTURE_LOW:    reg_rdata <= capture_pair_r[7:0];
                `OFS_CAPTURE_HIGH:   reg_rdata <= capture_pair_r[15:8];
                `OFS_CCU_CONTROL:
                    reg_rdata <= {4'h0, ccu_flag_r, ccu_r[2:0]};
                default: reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

endmodule : gated_sixteen_bit_timer

/* tb/gated_timer_properties.sv */
`timescale 1ns/1ps
`include "gated_timer_defs.svh"

module gated_timer_checker
    import gated_timer_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       sleep_mode,
    input wire logic       low_power_osc_on,
    input wire logic       core_irq,
    input wire logic       wake_request,
    input wire logic       compare_match
);
    // ********
    // port relations
    // ********
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);

    byte_t ctrl_r;

    // shadow of the control byte, kept from the bus alone
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            ctrl_r <= `RST_CONTROL;
        else if (reg_wr && reg_addr == `OFS_TIMER_ONE_CONTROL)
            ctrl_r <= reg_wdata;
    end

    a_ctrl_read_back: assert property (
        reg_rd && reg_addr == `OFS_TIMER_ONE_CONTROL |=> reg_rdata == ctrl_r)
        else $error("control read back differs");
    a_osc_follows_bit: assert property (
        reg_wr && reg_addr == `OFS_TIMER_ONE_CONTROL
        |=> low_power_osc_on == $past(reg_wdata[3]))
        else $error("oscillator enable does not follow bit 3");
    a_osc_holds_still: assert property (
        !(reg_wr && reg_addr == `OFS_TIMER_ONE_CONTROL)
        |=> $stable(low_power_osc_on))
        else $error("oscillator enable moved without a write");
    a_irq_global_off: assert property (
        reg_wr && reg_addr == `OFS_CORE_IRQ_CONTROL && !reg_wdata[7]
        |=> !core_irq)
        else $error("request with global enable clear");
    a_wake_periph_off: assert property (
        reg_wr && reg_addr == `OFS_CORE_IRQ_CONTROL && !reg_wdata[6]
        |=> !wake_request && !core_irq)
        else $error("wake or request with peripheral enable clear");
    a_roll_enable_off: assert property (
        reg_wr && reg_addr == `OFS_ENABLE_REG && !reg_wdata[0]
        |=> !core_irq && !wake_request)
        else $error("request with rollover enable clear");
    a_wake_only_asleep: assert property (
        wake_request |-> sleep_mode)
        else $error("wake request while awake");
    a_flag_stays_set: assert property (
        core_irq && !reg_wr |=> core_irq)
        else $error("request dropped without a write");
    a_match_mode_off: assert property (
        reg_wr && reg_addr == `OFS_CCU_CONTROL && !reg_wdata[1]
        |=> !compare_match)
        else $error("match outside compare mode");
    a_rdata_quiet: assert property (
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read slot");
endmodule : gated_timer_checker

bind gated_sixteen_bit_timer gated_timer_checker props_i (
    .core_clk(core_clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .sleep_mode(sleep_mode),
    .low_power_osc_on(low_power_osc_on),
    .core_irq(core_irq),
    .wake_request(wake_request),
    .compare_match(compare_match)
);

/* tb/pin_partner.sv */
`timescale 1ns/1ps

module pin_partner (
    input  wire logic core_clk,
    output logic      external_clock_pin,
    output logic      gate_pin,
    output logic      second_comparator_output
);
    // ********
    // pin driving
    // ********
    initial
    begin
        external_clock_pin       = 1'b0;
        gate_pin                 = 1'b1;
        second_comparator_output = 1'b1;
    end

    // clock stands still between bursts, so edges come only from here
    task automatic toggle(input int n, input int half);
        repeat (n)
        begin
            repeat (half) @(posedge core_clk);
            external_clock_pin <= ~external_clock_pin;
        end
    endtask : toggle

    task automatic levels(input logic g, input logic c);
        @(posedge core_clk);
        gate_pin                 <= g;
        second_comparator_output <= c;
    endtask : levels
endmodule : pin_partner

/* tb/tb_gated_sixteen_bit_timer.sv */
`timescale 1ns/1ps
`include "gated_timer_defs.svh"

module tb_gated_sixteen_bit_timer
    import gated_timer_pkg::*;
;
    localparam logic [3:0] ctl_a = `OFS_TIMER_ONE_CONTROL;
    localparam logic [3:0] cnt_a = `OFS_COUNT_LOW_BYTE;
    localparam logic [3:0] flg_a = `OFS_FLAG_REG;
    localparam logic [3:0] ena_a = `OFS_ENABLE_REG;
    localparam logic [3:0] irq_a = `OFS_CORE_IRQ_CONTROL;
    localparam logic [3:0] aux_a = `OFS_COMPARATOR_AUX;
    localparam logic [3:0] cmp_a = `OFS_COMPARE_LOW;
    localparam logic [3:0] cap_a = `OFS_CAPTURE_LOW;
    localparam logic [3:0] ccu_a = `OFS_CCU_CONTROL;

    logic       core_clk      = 1'b0;
    logic       rst           = 1'b1;
    logic [3:0] reg_addr      = 4'h0;
    byte_t      reg_wdata     = 8'h00;
    logic       reg_wr        = 1'b0;
    logic       reg_rd        = 1'b0;
    logic       capture_event = 1'b0;
    logic       sleep_mode    = 1'b0;
    byte_t      reg_rdata;
    logic       external_clock_pin;
    logic       gate_pin;
    logic       second_comparator_output;
    logic       low_power_osc_on;
    logic       core_irq;
    logic       wake_request;
    logic       compare_match;
    int         err_total     = 0;
    int         cmp_count     = 0;
    int         seed          = 73;
    byte_t      b;
    count_t     c;
    count_t     v;
    count_t     e;
    logic       p;

    always #20 core_clk = ~core_clk;

    gated_sixteen_bit_timer dut (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .external_clock_pin(external_clock_pin),
        .gate_pin(gate_pin),
        .second_comparator_output(second_comparator_output),
        .capture_event(capture_event), .sleep_mode(sleep_mode),
        .low_power_osc_on(low_power_osc_on), .core_irq(core_irq),
        .wake_request(wake_request), .compare_match(compare_match)
    );

    pin_partner part (
        .core_clk(core_clk),
        .external_clock_pin(external_clock_pin),
        .gate_pin(gate_pin),
        .second_comparator_output(second_comparator_output)
    );

    // ********
    // helpers
    // ********
    task automatic close_out();
        if (err_total == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    task automatic chk(input count_t seen, input count_t exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    function automatic count_t z(input logic x);
        return {15'h0000, x};
    endfunction : z

    // counts sampled against a free-running divider may land one off
    function automatic count_t fit(input count_t c, input count_t e);
        return (c + 16'h0001 - e <= 16'h0002) ? e : c;
    endfunction : fit

    function automatic byte_t ctl(input logic on, cs, sy,
                                  input logic [1:0] ps,
                                  input logic ge, inv);
        return {inv, ge, ps, 1'b0, sy, cs, on};
    endfunction : ctl

    task automatic wr(input logic [3:0] a, input byte_t d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output byte_t d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic rdchk(input logic [3:0] a, input byte_t x);
        byte_t d;
        rd(a, d);
        chk({8'h00, d}, {8'h00, x});
    endtask : rdchk

    task automatic rd16(input logic [3:0] a, output count_t w);
        byte_t lo;
        byte_t hi;
        rd(a, lo);
        rd(a + 4'h1, hi);
        w = {hi, lo};
    endtask : rd16

    task automatic set16(input logic [3:0] a, input count_t w);
        wr(a, w[7:0]);
        wr(a + 4'h1, w[15:8]);
    endtask : set16

    task automatic run(input byte_t x, input int n);
        wr(ctl_a, x);
        repeat (n) @(posedge core_clk);
        wr(ctl_a, 8'h00);
    endtask : run

    initial
    begin
        repeat (90000) @(posedge core_clk);
        err_total++;
        close_out();
    end

    // ********
    // scenarios
    // ********
    initial
    begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        rdchk(ctl_a, `RST_CONTROL);
        rdchk(aux_a, `RST_AUX);
        wr(4'hf, 8'h5a);
        rdchk(4'hf, 8'h00);
        b = byte_t'($random(seed)) & 8'hfe;
        wr(ctl_a, b);
        rdchk(ctl_a, b);
        chk(z(low_power_osc_on), z(b[3]));
        wr(ctl_a, 8'h00);
        repeat (4)
        begin
            v = count_t'($random(seed));
            set16(cnt_a, v);
            repeat (20) @(posedge core_clk);
            rd16(cnt_a, c);
            chk(c, v);
        end
        for (int ps = 0; ps < 4; ps++)
        begin
            set16(cnt_a, 16'h0000);
            b = ctl(1'b1, 1'b0, 1'($random(seed)), ps[1:0], 1'b0, 1'b0);
            run(b, 40 << ps);
            rd16(cnt_a, c);
            chk(fit(c, 16'h000a), 16'h000a);
        end
        for (int g = 0; g < 4; g++)
        begin
            wr(aux_a, {6'h00, g[1], 1'b1});
            for (int k = 0; k < 3; k++)
            begin
                p = ~(g[0] ^ g[1]) ^ (k == 2);
                part.levels(p, ~p);
                set16(cnt_a, 16'h0000);
                run(ctl(1'b1, 1'b0, 1'b0, 2'b00, k != 1, g[0]), 100);
                rd16(cnt_a, c);
                e = (k == 0) ? 16'h0000 : 16'h0019;
                chk((k == 0) ? c : fit(c, e), e);
            end
        end
        set16(cnt_a, 16'hfffe);
        run(ctl(1'b1, 1'b0, 1'b0, 2'b00, 1'b0, 1'b0), 40);
        rd16(cnt_a, c);
        chk({8'h00, c[15:8]}, 16'h0000);
        rdchk(flg_a, 8'h01);
        for (int m = 0; m < 8; m++)
        begin
            wr(ena_a, {7'h00, m[0]});
            wr(irq_a, {m[2:1], 6'h00});
            #1 chk(z(core_irq), z(&m[2:0]));
        end
        wr(flg_a, 8'h01);
        #1 chk(z(core_irq), 16'h0001);
        wr(flg_a, 8'h00);
        #1 chk(z(core_irq), 16'h0000);
        wr(ccu_a, 8'h06);
        set16(cnt_a, 16'h0000);
        #1 chk(z(compare_match), 16'h0001);
        wr(cnt_a, 8'h33);
        rdchk(cnt_a, 8'h33);
        set16(cmp_a, 16'h0010);
        set16(cnt_a, 16'h0000);
        run(ctl(1'b1, 1'b0, 1'b0, 2'b00, 1'b0, 1'b0), 200);
        rd16(cnt_a, c);
        chk(z(c > 16'h0010), 16'h0000);
        rdchk(flg_a, 8'h00);
        // a period of ffff makes the clear look like a wrap
        set16(cmp_a, 16'hffff);
        set16(cnt_a, 16'hfff0);
        run(ctl(1'b1, 1'b0, 1'b0, 2'b00, 1'b0, 1'b0), 100);
        rdchk(flg_a, 8'h00);
        wr(ccu_a, 8'h01);
        v = count_t'($random(seed));
        set16(cnt_a, v);
        @(posedge core_clk);
        capture_event <= 1'b1;
        @(posedge core_clk);
        capture_event <= 1'b0;
        rd16(cap_a, c);
        chk(c, v);
        for (int s = 0; s < 2; s++)
        begin
            set16(cnt_a, 16'h0000);
            wr(ctl_a, ctl(1'b1, 1'b1, s[0], 2'b00, 1'b0, 1'b0));
            part.toggle(10, 8);
            wr(ctl_a, 8'h00);
            rd16(cnt_a, c);
            chk(c, 16'h0004);
        end
        wr(irq_a, 8'hc0);
        set16(cnt_a, 16'hfffe);
        sleep_mode <= 1'b1;
        wr(ctl_a, ctl(1'b1, 1'b1, 1'b1, 2'b00, 1'b0, 1'b0));
        part.toggle(6, 8);
        repeat (4) @(posedge core_clk);
        #1 chk(z(wake_request), 16'h0001);
        chk(z(core_irq), 16'h0001);
        wr(flg_a, 8'h00);
        set16(cnt_a, 16'h0000);
        run(ctl(1'b1, 1'b0, 1'b0, 2'b00, 1'b0, 1'b0), 100);
        rd16(cnt_a, c);
        chk(c, 16'h0000);
        sleep_mode <= 1'b0;
        close_out();
    end
endmodule : tb_gated_sixteen_bit_timer
